// ===== rtl/timer8_pkg.sv
// Purpose: constants and types shared by the 8-bit timer/counter
// Assumes: Avalon-MM slave with 32-bit data, word addressing by byte address
// Notes: register layout below is local to this block
package timer8_pkg;

  // register byte addresses
  localparam logic [3:0] ADDR_COUNT = 4'h0;
  localparam logic [3:0] ADDR_CMPA = 4'h4;
  localparam logic [3:0] ADDR_CMPB = 4'h8;
  localparam logic [3:0] ADDR_CTRL = 4'hC;

  // address bit 4 selects the flag and mask words
  localparam logic [4:0] ADDR_FLAG = 5'h10;
  localparam logic [4:0] ADDR_MASK = 5'h14;

  // flag and mask bit positions
  localparam int FLAG_OVF = 0;
  localparam int FLAG_CMPA = 1;
  localparam int FLAG_CMPB = 2;

  // control word field positions
  localparam int CTRL_CS_LSB = 0;
  localparam int CTRL_WGM_LSB = 3;
  localparam int CTRL_COMA_LSB = 6;
  localparam int CTRL_COMB_LSB = 8;
  localparam int CTRL_ACK_LSB = 10;

  // counter limits
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;

  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [2:0] RESET_FLAGS = 3'h0;
  localparam logic [2:0] CS_OFF = 3'h0;
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [2:0] WGM_NORMAL = 3'h0;

  // prescaler width (divide by up to 1024)
  localparam int PRE_BITS = 10;
  localparam logic [PRE_BITS-1:0] PRE_ZERO = 10'h000;

  // clock select codes
  typedef enum logic [2:0] {
    CS_NONE = 3'h0, CS_DIV1 = 3'h1, CS_DIV8 = 3'h2, CS_DIV64 = 3'h3,
    CS_DIV256 = 3'h4, CS_DIV1024 = 3'h5, CS_EXT_FALL = 3'h6, CS_EXT_RISE = 3'h7
  } clock_select_field_e;

  // waveform generation modes
  typedef enum logic [2:0] {
    WG_NORMAL = 3'h0, WG_PC_PWM_MAX = 3'h1, WG_CTC = 3'h2, WG_FAST_MAX = 3'h3,
    WG_RSVD4 = 3'h4, WG_PC_PWM_A = 3'h5, WG_RSVD6 = 3'h6, WG_FAST_A = 3'h7
  } wgm_e;

  // control word as held by the block
  typedef struct packed {
    logic [1:0] comB;
    logic [1:0] comA;
    wgm_e wgm;
    clock_select_field_e clockSelect;
  } ctrl_s;

  // the three interrupt sources, one bit each
  typedef struct packed {
    logic cmpB;
    logic cmpA;
    logic ovf;
  } flags_s;

endpackage

// ===== rtl/timer_counter_8bit_pwm.sv
// Purpose: 8-bit timer/counter with two compare units and PWM outputs
// Assumes: single sys_clk domain, Avalon-MM register slave, external clock pin asynchronous
// Notes: one-cycle waitrequest on every access; compare pins come from the internal output latches
`timescale 1ns/1ps
`default_nettype none

module timer_counter_8bit_pwm
  import timer8_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // pins
  input wire logic externalClockPin,
  output logic compareOutputA,
  output logic compareOutputB,
  // interrupt requests, one per source
  output logic [2:0] irqReq
);

  logic [7:0] countReg;
  logic [7:0] cmpAReg;
  logic [7:0] cmpBReg;
  logic [7:0] bufAReg;
  logic [7:0] bufBReg;
  ctrl_s ctrlReg;
  flags_s flagReg;
  flags_s maskReg;
  logic ackReg;
  logic waitReg;
  logic [31:0] rdReg;
  logic [PRE_BITS-1:0] preReg;
  logic extSync1Reg;
  logic extSync2Reg;
  logic extPrevReg;
  logic upReg;
  logic blockReg;
  logic ocAReg;
  logic ocBReg;
  logic [2:0] irqReg;

  logic tick;
  logic pwmMode;
  logic phaseMode;
  logic ctcMode;
  logic [7:0] topVal;
  logic [7:0] countNext;
  logic upNext;
  logic atTop;
  logic atBottom;
  logic ovfEvent;
  logic cpuCountWr;
  logic accept;
  logic wrFlag;
  logic matchA;
  logic matchB;

  // one wait cycle, then the access completes; avoids a combinational path to waitrequest
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ackReg <= 1'b0;
      waitReg <= 1'b1;
    end else begin
      ackReg <= (avs_read || avs_write) && !ackReg;
      waitReg <= !((avs_read || avs_write) && !ackReg); // always the inverse of ackReg, kept as its own flop
    end
  end
  assign accept = ackReg && (avs_read || avs_write);
  assign avs_waitrequest = waitReg;
  assign cpuCountWr = accept && avs_write && avs_address == {1'b0, ADDR_COUNT};
  assign wrFlag = accept && avs_write && avs_address == ADDR_FLAG;

  // external pin passes two flops before edge detection
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      extSync1Reg <= 1'b0;
      extSync2Reg <= 1'b0;
      extPrevReg <= 1'b0;
    end else begin
      extSync1Reg <= externalClockPin;
      extSync2Reg <= extSync1Reg;
      extPrevReg <= extSync2Reg;
    end
  end

  // free-running prescaler
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      preReg <= PRE_ZERO;
    end else begin
      preReg <= preReg + 10'h001;
    end
  end

  // timer clock enable: source and edge from the select field
  always_comb begin
    case (ctrlReg.clockSelect)
      CS_NONE: tick = 1'b0; // stopped
      CS_DIV1: tick = 1'b1;
      CS_DIV8: tick = &preReg[2:0];
      CS_DIV64: tick = &preReg[5:0];
      CS_DIV256: tick = &preReg[7:0];
      CS_DIV1024: tick = &preReg[9:0];
      CS_EXT_FALL: tick = extPrevReg && !extSync2Reg;
      CS_EXT_RISE: tick = !extPrevReg && extSync2Reg;
      default: tick = 1'b0;
    endcase
  end

  // mode decode and limits
  assign pwmMode = ctrlReg.wgm == WG_PC_PWM_MAX || ctrlReg.wgm == WG_FAST_MAX ||
                   ctrlReg.wgm == WG_PC_PWM_A || ctrlReg.wgm == WG_FAST_A;
  assign phaseMode = ctrlReg.wgm == WG_PC_PWM_MAX || ctrlReg.wgm == WG_PC_PWM_A;
  assign ctcMode = ctrlReg.wgm == WG_CTC;
  assign topVal = (ctcMode || ctrlReg.wgm == WG_PC_PWM_A || ctrlReg.wgm == WG_FAST_A)
                  ? cmpAReg : COUNT_MAX;
  assign atTop = countReg == topVal;
  assign atBottom = countReg == COUNT_BOTTOM;

  // next count value per mode
  always_comb begin
    countNext = countReg;
    upNext = upReg;
    ovfEvent = 1'b0;
    if (phaseMode) begin
      if (upReg) begin
        if (atTop) begin
          upNext = 1'b0;
          countNext = countReg - 8'h01;
        end else begin
          countNext = countReg + 8'h01;
        end
      end else if (atBottom) begin
        upNext = 1'b1;
        countNext = countReg + 8'h01;
        ovfEvent = 1'b1; // phase correct overflows at bottom
      end else begin
        countNext = countReg - 8'h01;
      end
    end else if (atTop && topVal != COUNT_MAX) begin
      countNext = COUNT_BOTTOM; // auto reload
      upNext = 1'b1;
      ovfEvent = !ctcMode; // ctc overflows only at max
    end else begin
      countNext = countReg + 8'h01;
      upNext = 1'b1;
      ovfEvent = countReg == COUNT_MAX;
    end
  end

  // counter; a cpu write wins over any count or clear
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      countReg <= RESET_BYTE;
      upReg <= 1'b1;
    end else if (cpuCountWr) begin
      countReg <= avs_writedata[7:0];
    end else if (tick) begin
      countReg <= countNext;
      upReg <= upNext;
    end
  end

  // a counter write blocks compare matches in the next timer tick
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      blockReg <= 1'b0;
    end else if (cpuCountWr) begin
      blockReg <= 1'b1;
    end else if (tick) begin
      blockReg <= 1'b0;
    end
  end

  // compare buffers; pwm modes apply at top or bottom to avoid odd pulses
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      bufAReg <= RESET_BYTE;
      bufBReg <= RESET_BYTE;
      cmpAReg <= RESET_BYTE;
      cmpBReg <= RESET_BYTE;
    end else begin
      if (accept && avs_write && avs_address == {1'b0, ADDR_CMPA}) begin
        bufAReg <= avs_writedata[7:0];
      end
      if (accept && avs_write && avs_address == {1'b0, ADDR_CMPB}) begin
        bufBReg <= avs_writedata[7:0];
      end
      if (!pwmMode || (tick && (phaseMode ? atTop : atBottom))) begin
        cmpAReg <= bufAReg;
        cmpBReg <= bufBReg;
      end
    end
  end

  // comparators run every cycle; the tick that leaves the matching count sets the flag
  assign matchA = countReg == cmpAReg && !blockReg;
  assign matchB = countReg == cmpBReg && !blockReg;

  // flags: hardware set wins over a software clear
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      flagReg <= RESET_FLAGS;
    end else begin
      flagReg.ovf <= (tick && ovfEvent) ||
                     (flagReg.ovf && !(wrFlag && avs_writedata[FLAG_OVF]) &&
                      !(accept && avs_write && avs_address == {1'b0, ADDR_CTRL} &&
                        avs_writedata[CTRL_ACK_LSB + FLAG_OVF]));
      flagReg.cmpA <= (tick && matchA) ||
                      (flagReg.cmpA && !(wrFlag && avs_writedata[FLAG_CMPA]) &&
                       !(accept && avs_write && avs_address == {1'b0, ADDR_CTRL} &&
                         avs_writedata[CTRL_ACK_LSB + FLAG_CMPA]));
      flagReg.cmpB <= (tick && matchB) ||
                      (flagReg.cmpB && !(wrFlag && avs_writedata[FLAG_CMPB]) &&
                       !(accept && avs_write && avs_address == {1'b0, ADDR_CTRL} &&
                         avs_writedata[CTRL_ACK_LSB + FLAG_CMPB]));
    end
  end

  // control and mask registers
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ctrlReg <= {COM_OFF, COM_OFF, WGM_NORMAL, CS_OFF};
      maskReg <= RESET_FLAGS;
    end else if (accept && avs_write) begin
      if (avs_address == {1'b0, ADDR_CTRL}) begin
        ctrlReg <= avs_writedata[CTRL_ACK_LSB-1:0];
      end
      if (avs_address == ADDR_MASK) begin
        maskReg <= avs_writedata[2:0];
      end
    end
  end

  // interrupt requests gated by mask
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      irqReg <= RESET_FLAGS;
    end else begin
      irqReg <= flagReg & maskReg;
    end
  end
  assign irqReq = irqReg;

  // waveform generator: toggle (non-pwm), clear or set on match; fast pwm sets at bottom for clear on match, else clears
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ocAReg <= 1'b0;
      ocBReg <= 1'b0;
    end else if (tick) begin
      if (matchA) begin
        case (ctrlReg.comA)
          2'h1: ocAReg <= pwmMode ? ocAReg : !ocAReg;
          2'h2: ocAReg <= phaseMode ? upReg ? 1'b0 : 1'b1 : 1'b0;
          2'h3: ocAReg <= phaseMode ? upReg ? 1'b1 : 1'b0 : 1'b1;
          default: ocAReg <= ocAReg;
        endcase
      end else if (pwmMode && !phaseMode && atBottom) begin
        ocAReg <= ctrlReg.comA == 2'h2;
      end
      if (matchB) begin
        case (ctrlReg.comB)
          2'h1: ocBReg <= pwmMode ? ocBReg : !ocBReg;
          2'h2: ocBReg <= phaseMode ? upReg ? 1'b0 : 1'b1 : 1'b0;
          2'h3: ocBReg <= phaseMode ? upReg ? 1'b1 : 1'b0 : 1'b1;
          default: ocBReg <= ocBReg;
        endcase
      end else if (pwmMode && !phaseMode && atBottom) begin
        ocBReg <= ctrlReg.comB == 2'h2;
      end
    end
  end
  assign compareOutputA = ocAReg;
  assign compareOutputB = ocBReg;

  // read data registered in the wait cycle, ready for the completing cycle; unmapped reads give zero
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rdReg <= 32'h00000000;
    end else if (avs_read && !ackReg) begin
      case (avs_address)
        {1'b0, ADDR_COUNT}: rdReg <= {24'h000000, countReg};
        {1'b0, ADDR_CMPA}: rdReg <= {24'h000000, pwmMode ? bufAReg : cmpAReg};
        {1'b0, ADDR_CMPB}: rdReg <= {24'h000000, pwmMode ? bufBReg : cmpBReg};
        {1'b0, ADDR_CTRL}: rdReg <= {22'h000000, ctrlReg};
        ADDR_FLAG: rdReg <= {29'h00000000, flagReg};
        ADDR_MASK: rdReg <= {29'h00000000, maskReg};
        default: rdReg <= 32'h00000000;
      endcase
    end
  end
  assign avs_readdata = rdReg;

  // counter write takes priority over a tick in the same cycle
  cpu_write_wins_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cpuCountWr |=> countReg == $past(avs_writedata[7:0])) else $error("counter write lost");
  stopped_holds_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (ctrlReg.clockSelect == CS_NONE && !cpuCountWr) |=> $stable(countReg)) else $error("counter moved");
  flag_after_match_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (tick && matchA) |=> flagReg.cmpA) else $error("compare A flag not set");
  match_b_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (tick && matchB) |=> flagReg.cmpB) else $error("compare B flag not set");
  irq_gating_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ##1 irqReq == $past(flagReg & maskReg)) else $error("irq not gated");
  flag_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (wrFlag && avs_writedata[FLAG_OVF] && !(tick && ovfEvent)) |=> !flagReg.ovf)
    else $error("overflow flag not cleared");
  ctc_reload_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (ctcMode && tick && atTop && cmpAReg != COUNT_MAX && !cpuCountWr) |=> countReg == COUNT_BOTTOM)
    else $error("ctc did not reload");
  normal_wrap_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (ctrlReg.wgm == WG_NORMAL && tick && countReg == COUNT_MAX && !cpuCountWr) |=> flagReg.ovf && countReg == 8'h00)
    else $error("no overflow at max");
  buffer_direct_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!pwmMode && $past(!pwmMode)) |-> cmpAReg == $past(bufAReg)) else $error("compare A not applied");

endmodule // timer_counter_8bit_pwm
`default_nettype wire

// ===== verif/tb.sv
// Purpose: self-checking bench for the 8-bit timer/counter
// Assumes: one wait cycle per bus access, external pin passes two sync flops
// Notes: external pin pulses give exact tick counts; prescaled runs are checked in a window
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin err_total++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end

module tb;
  import timer8_pkg::*;

  // clock, reset and bus
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] avsAddress = 5'h00;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h0;
  logic [31:0] avsReaddata;
  logic avsWaitrequest;
  // pins and requests
  logic extPin = 1'b0;
  logic cmpOutA;
  logic cmpOutB;
  logic [2:0] irqReq;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [31:0] v;
  logic [31:0] rd;
  logic [2:0] m;
  int k;
  int divs [5] = '{1, 8, 64, 256, 1024};
  logic [4:0] regAdr [7] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h14, 5'h18};

  timer_counter_8bit_pwm dut (.sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avsAddress),
    .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
    .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest), .externalClockPin(extPin),
    .compareOutputA(cmpOutA), .compareOutputB(cmpOutB), .irqReq(irqReq));

  always #10 sys_clk = ~sys_clk;

  // hang guard: whole run is well under this many cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      close_out();
    end
  end

  function automatic logic [7:0] ctc_exp(int ticks, int top);
    return 8'(ticks % (top + 1));
  endfunction

  function automatic logic in_window(logic [7:0] c, int waitCyc, int div);
    return (int'(c) >= waitCyc / div - 1) && (int'(c) <= (waitCyc + 8) / div + 1);
  endfunction

  // one avalon access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] adr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    avsAddress <= adr;
    avsWritedata <= wd;
    avsWrite <= wr;
    avsRead <= !wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 50);
    rd = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    if (n >= 50) begin
      err_total++;
      $display("CHECK FAILED waitrequest expected 0 seen 1");
      close_out();
    end
  endtask

  task automatic wreg(input logic [4:0] adr, input logic [31:0] wd);
    bus(1'b1, adr, wd);
  endtask

  task automatic rchk(input string nm, input logic [4:0] adr, input logic [31:0] ex);
    bus(1'b0, adr, 32'h0);
    `CHK(nm, ex, rd)
  endtask

  // full pin pulses, slow enough for the synchroniser
  task automatic pulses(input int cnt);
    repeat (cnt) begin
      @(posedge sys_clk);
      extPin <= 1'b1;
      repeat (4) @(posedge sys_clk);
      extPin <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic endt(input string nm);
    $display("test %s done, checks %0d, mismatches %0d", nm, n_checks, err_total);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    void'($urandom(20));
    // reset values, the last address is unmapped and reads zero
    foreach (regAdr[i]) rchk("reset", regAdr[i], 32'h0);
    `CHK("irq", 3'h0, irqReq)
    endt("reset");
    // random loads while stopped, then exact pin ticks on both edges
    for (int i = 0; i < 6; i++) begin
      v = $urandom;
      wreg(5'h00, v);
      wreg(5'h08, ~v);
      repeat (20) @(posedge sys_clk);
      rchk("count", 5'h00, {24'h0, v[7:0]});
      rchk("cmpB", 5'h08, {24'h0, ~v[7:0]});
      k = $urandom_range(1, 5);
      wreg(5'h0C, (i % 2) ? 32'h6 : 32'h7);
      pulses(k);
      wreg(5'h0C, 32'h0);
      rchk("pincount", 5'h00, {24'h0, v[7:0] + 8'(k)});
    end
    endt("pinclock");
    // every prescaled source counts in its window
    for (int c = 1; c <= 5; c++) begin
      wreg(5'h00, 32'h0);
      wreg(5'h0C, 32'(c));
      repeat (divs[c-1] * 4 + 10) @(posedge sys_clk);
      wreg(5'h0C, 32'h0);
      bus(1'b0, 5'h00, 32'h0);
      `CHK("presc", 1'b1, in_window(rd[7:0], divs[c-1] * 4 + 10, divs[c-1]))
    end
    // cpu write lands while running at full rate
    wreg(5'h0C, 32'h1);
    wreg(5'h00, 32'h80);
    bus(1'b0, 5'h00, 32'h0);
    wreg(5'h0C, 32'h0);
    `CHK("cpuwrite", 1'b1, rd[7:0] >= 8'h80 && rd[7:0] <= 8'h88)
    endt("prescaler");
    // compare flags one tick after the match, then mask, clear and acknowledge
    wreg(5'h10, 32'h7);
    wreg(5'h00, 32'h5);
    wreg(5'h04, 32'h6);
    wreg(5'h08, 32'h7);
    wreg(5'h0C, 32'h7);
    pulses(1);
    rchk("flag1", 5'h10, 32'h0);
    pulses(1);
    rchk("flag2", 5'h10, 32'h2);
    pulses(1);
    rchk("flag3", 5'h10, 32'h6);
    m = 3'($urandom_range(0, 7));
    wreg(5'h14, {29'h0, m});
    rchk("mask", 5'h14, {29'h0, m});
    `CHK("irq", 3'h6 & m, irqReq)
    wreg(5'h10, 32'h2);
    rchk("clrA", 5'h10, 32'h4);
    wreg(5'h0C, 32'h1C07);
    rchk("ack", 5'h10, 32'h0);
    `CHK("irq0", 3'h0, irqReq)
    wreg(5'h00, 32'hFE);
    pulses(2);
    rchk("ovf", 5'h10, 32'h1);
    rchk("bottom", 5'h00, 32'h0);
    wreg(5'h14, 32'h7);
    repeat (2) @(posedge sys_clk);
    `CHK("irqovf", 3'h1, irqReq)
    endt("flags");
    // clear on compare with toggling compare pin
    wreg(5'h0C, 32'h0);
    wreg(5'h04, 32'h3);
    wreg(5'h00, 32'h0);
    wreg(5'h0C, 32'h57);
    pulses(5);
    rchk("ctc5", 5'h00, {24'h0, ctc_exp(5, 3)});
    `CHK("pinA1", 1'b1, cmpOutA)
    pulses(4);
    rchk("ctc9", 5'h00, {24'h0, ctc_exp(9, 3)});
    `CHK("pinA0", 1'b0, cmpOutA)
    endt("ctc");
    // fast pwm to max, clear on match: a compare write waits in its buffer until bottom
    wreg(5'h0C, 32'h9F);
    wreg(5'h04, 32'h20);
    rchk("bufrd", 5'h04, 32'h20);
    wreg(5'h10, 32'h7);
    wreg(5'h00, 32'h1F);
    pulses(2);
    rchk("held", 5'h10, 32'h0);
    wreg(5'h00, 32'hFF);
    pulses(2);
    `CHK("pwmset", 1'b1, cmpOutA)
    wreg(5'h00, 32'h1F);
    pulses(2);
    rchk("applied", 5'h10, 32'h3);
    `CHK("pwmclr", 1'b0, cmpOutA)
    endt("pwm");
    close_out();
  end
endmodule // tb
`default_nettype wire
